/* ine_regs.vh */
`ifndef INE_REGS_VH
`define INE_REGS_VH
`define INE_ENTRY_CYCLES 4'd9
`define INE_MAX_LATENCY 5'd30
`define INE_MAX_LATENCY_SHORT 5'd15
`define INE_DIV_CYCLES 5'd21
`define INE_LONG_CYCLES 5'd6
`define INE_VECTOR_TOP 16'hfffa
`define INE_NUM_REQ 4'd12
`define INE_LEVEL_NONE 2'h3
`define INE_LEVEL_MAIN 2'h3
`define INE_STACK_TOP 16'h027f
`define INE_CCR_LVL_HI 5
`define INE_CCR_LVL_LO 4
`define INE_CCR_IE 3
`define INE_CCR_RESET 8'h38
`endif

/* ine_stack.v */
`timescale 1ns/1ps
`include "ine_regs.vh"
// Stack pointer; pushes pre-decrement, pops post-increment so the stack grows down
module ine_stack #(
   parameter [15:0] TOP = `INE_STACK_TOP
) (
   input wire clk_in,
   input wire srst_in,
   input wire load_in,
   input wire [15:0] load_val_in,
   input wire push_in,
   input wire pop_in,
   output wire [15:0] addr_out,
   output wire [15:0] sp_out
);
   reg [15:0] sp_r;
   reg [15:0] sp_nxt;
   always @* begin
      sp_nxt = sp_r;
      if (load_in) begin
         sp_nxt = load_val_in;
      end else if (push_in) begin
         sp_nxt = sp_r - 16'h0001;
      end else if (pop_in) begin
         sp_nxt = sp_r + 16'h0001;
      end
   end
   always @(posedge clk_in) begin
      if (srst_in) begin
         sp_r <= TOP;
      end else begin
         sp_r <= sp_nxt;
      end
   end
   // Push writes below the current top; pop reads the current top
   assign addr_out = push_in ? (sp_r - 16'h0001) : sp_r;
   assign sp_out = sp_r;
endmodule

/* ine_core.v */
`timescale 1ns/1ps
`include "ine_regs.vh"
module ine_core #(
   parameter [15:0] STACK_TOP = `INE_STACK_TOP
) (
   input wire clk_in,
   input wire srst_in,
   input wire instr_last_in,
   input wire req_valid_in,
   input wire [1:0] req_level_in,
   input wire [3:0] req_index_in,
   input wire [15:0] pc_in,
   input wire [7:0] ccr_wr_data_in,
   input wire ccr_wr_in,
   input wire sp_wr_in,
   input wire [15:0] sp_wr_data_in,
   input wire call_in,
   input wire ret_in,
   input wire return_from_irq_op_in,
   input wire [7:0] mem_rd_data_in,
   output reg busy_out,
   output reg accept_out,
   output reg [7:0] condition_code_reg_out,
   output reg [15:0] pc_load_out,
   output reg pc_load_valid_out,
   output reg [15:0] mem_addr_out,
   output reg [7:0] mem_wr_data_out,
   output reg mem_wr_out,
   output reg mem_rd_out,
   output wire [15:0] sp_out
);
   localparam [5:0] ST_IDLE = 6'h01;
   localparam [5:0] ST_ENTRY = 6'h02;
   localparam [5:0] ST_RETURN_FROM_IRQ_OP = 6'h04;
   localparam [5:0] ST_CALL = 6'h08;
   localparam [5:0] ST_RET = 6'h10;
   localparam [5:0] ST_DONE = 6'h20;

   // Vector address of request n; upper byte first
   function [15:0] vec_addr;
      input [3:0] idx;
      begin
         vec_addr = `INE_VECTOR_TOP - {11'h000, idx, 1'b0};
      end
   endfunction

   reg [5:0] state_r;
   reg [3:0] cnt_r;
   reg [1:0] lvl_r;
   reg [15:0] vec_r;
   reg [15:0] pc_r;
   reg [7:0] tmp_r;
   reg push_w;
   reg pop_w;
   wire [15:0] stk_addr;
   wire [1:0] cur_lvl;
   wire take;

   assign cur_lvl = {condition_code_reg_out[`INE_CCR_LVL_HI], condition_code_reg_out[`INE_CCR_LVL_LO]};
   // Level 3 can never compare lower than a level field of 3 or anything; explicit guard kept
   assign take = state_r == ST_IDLE && instr_last_in && req_valid_in
      && req_level_in != `INE_LEVEL_NONE
      && req_level_in < cur_lvl && condition_code_reg_out[`INE_CCR_IE]
      && cur_lvl != 2'h0
      && req_index_in < `INE_NUM_REQ;

   always @* begin
      push_w = 1'b0;
      pop_w = 1'b0;
      case (state_r)
         ST_ENTRY: push_w = cnt_r < 4'd3;
         ST_CALL: push_w = cnt_r < 4'd2;
         ST_RETURN_FROM_IRQ_OP: pop_w = cnt_r < 4'd3;
         ST_RET: pop_w = cnt_r < 4'd2;
         default: begin
            push_w = 1'b0;
            pop_w = 1'b0;
         end
      endcase
   end

   ine_stack #(.TOP(STACK_TOP)) u_stack (
      .clk_in(clk_in),
      .srst_in(srst_in),
      .load_in(sp_wr_in),
      .load_val_in(sp_wr_data_in),
      .push_in(push_w),
      .pop_in(pop_w),
      .addr_out(stk_addr),
      .sp_out(sp_out)
   );

   always @(posedge clk_in) begin
      if (srst_in) begin
         state_r <= ST_IDLE;
         cnt_r <= 4'h0;
         lvl_r <= 2'h0;
         vec_r <= 16'h0000;
         pc_r <= 16'h0000;
         tmp_r <= 8'h00;
         busy_out <= 1'b0;
         accept_out <= 1'b0;
         condition_code_reg_out <= `INE_CCR_RESET;
         pc_load_out <= 16'h0000;
         pc_load_valid_out <= 1'b0;
         mem_addr_out <= 16'h0000;
         mem_wr_data_out <= 8'h00;
         mem_wr_out <= 1'b0;
         mem_rd_out <= 1'b0;
      end else begin
         accept_out <= 1'b0;
         pc_load_valid_out <= 1'b0;
         mem_wr_out <= push_w;
         mem_rd_out <= pop_w;
         if (push_w || pop_w) begin
            mem_addr_out <= stk_addr;
         end
         if (ccr_wr_in && state_r == ST_IDLE) begin
            condition_code_reg_out <= ccr_wr_data_in;
         end
         case (state_r)
            ST_IDLE: begin
               cnt_r <= 4'h0;
               pc_r <= pc_in;
               if (take) begin
                  state_r <= ST_ENTRY;
                  lvl_r <= req_level_in;
                  vec_r <= vec_addr(req_index_in);
                  accept_out <= 1'b1;
                  busy_out <= 1'b1;
               end else if (return_from_irq_op_in) begin
                  state_r <= ST_RETURN_FROM_IRQ_OP;
                  busy_out <= 1'b1;
               end else if (call_in) begin
                  state_r <= ST_CALL;
                  busy_out <= 1'b1;
               end else if (ret_in) begin
                  state_r <= ST_RET;
                  busy_out <= 1'b1;
               end
            end
            ST_ENTRY: begin
               cnt_r <= cnt_r + 4'h1;
               // PC low, PC high, then status; A and T are left alone
               case (cnt_r)
                  4'd0: mem_wr_data_out <= pc_r[7:0];
                  4'd1: mem_wr_data_out <= pc_r[15:8];
                  4'd2: mem_wr_data_out <= condition_code_reg_out;
                  default: mem_wr_data_out <= mem_wr_data_out;
               endcase
               if (cnt_r == 4'd3) begin
                  condition_code_reg_out[`INE_CCR_LVL_HI] <= lvl_r[1];
                  condition_code_reg_out[`INE_CCR_LVL_LO] <= lvl_r[0];
               end
               // Fixed entry length keeps latency at longest instruction plus nine
               if (cnt_r == `INE_ENTRY_CYCLES - 4'd1) begin
                  pc_load_out <= vec_r;
                  pc_load_valid_out <= 1'b1;
                  state_r <= ST_DONE;
               end
            end
            ST_CALL: begin
               cnt_r <= cnt_r + 4'h1;
               if (cnt_r == 4'd0) mem_wr_data_out <= pc_r[7:0];
               else if (cnt_r == 4'd1) mem_wr_data_out <= pc_r[15:8];
               else state_r <= ST_DONE;
            end
            ST_RETURN_FROM_IRQ_OP: begin
               cnt_r <= cnt_r + 4'h1;
               // Read data is taken while the read strobe stands
               if (cnt_r == 4'd1) condition_code_reg_out <= mem_rd_data_in;
               if (cnt_r == 4'd2) tmp_r <= mem_rd_data_in;
               if (cnt_r == 4'd3) begin
                  pc_load_out <= {tmp_r, mem_rd_data_in};
                  pc_load_valid_out <= 1'b1;
                  state_r <= ST_DONE;
               end
            end
            ST_RET: begin
               cnt_r <= cnt_r + 4'h1;
               if (cnt_r == 4'd1) tmp_r <= mem_rd_data_in;
               if (cnt_r == 4'd2) begin
                  pc_load_out <= {tmp_r, mem_rd_data_in};
                  pc_load_valid_out <= 1'b1;
                  state_r <= ST_DONE;
               end
            end
            ST_DONE: begin
               busy_out <= 1'b0;
               state_r <= ST_IDLE;
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end
endmodule

/* ine_core_chk.sv */
`timescale 1ns/1ps
module ine_core_chk (
   input wire clk_in,
   input wire srst_in,
   input wire instr_last_in,
   input wire req_valid_in,
   input wire [1:0] req_level_in,
   input wire [3:0] req_index_in,
   input wire [15:0] pc_in,
   input wire busy_out,
   input wire accept_out,
   input wire [7:0] condition_code_reg_out,
   input wire [15:0] pc_load_out,
   input wire pc_load_valid_out,
   input wire [15:0] mem_addr_out,
   input wire [7:0] mem_wr_data_out,
   input wire mem_wr_out,
   input wire [15:0] sp_out
);
   wire [7:0] condition_code_reg = condition_code_reg_out;
   wire take = !busy_out && instr_last_in && req_valid_in && req_level_in != 2'h3
      && req_level_in < condition_code_reg[5:4] && condition_code_reg[3];
   default clocking @(posedge clk_in); endclocking
   default disable iff (srst_in);
   sequence push_pc;
      mem_wr_out && mem_addr_out == $past(sp_out) - 16'd1 && mem_wr_data_out == $past(pc_in[7:0]);
   endsequence
   sequence push_rest;
      mem_wr_out && mem_wr_data_out == $past(pc_in[15:8], 2) ##1 mem_wr_out
         && mem_wr_data_out == $past(condition_code_reg, 3) && mem_addr_out == $past(sp_out, 3) - 16'd3;
   endsequence
   AST_TAKE: assert property (take |=> accept_out) else $error("request not taken");
   AST_LAST: assert property (accept_out |-> $past(instr_last_in)) else $error("mid take");
   AST_NO_L3: assert property (accept_out |-> $past(req_level_in) != 2'h3) else $error("l3");
   AST_BLOCK: assert property (accept_out |-> $past(condition_code_reg[3]) && $past(condition_code_reg[5:4]) != 2'h0)
      else $error("blocked taken");
   AST_PUSH: assert property (accept_out |-> ##1 push_pc ##1 push_rest) else $error("push");
   AST_NO_ACC: assert property (accept_out |-> ##4 !mem_wr_out [*6]) else $error("extra");
   AST_ENTRY: assert property (accept_out |-> !pc_load_valid_out [*8] ##1 !pc_load_valid_out
      ##1 pc_load_valid_out) else $error("entry length");
   AST_VEC: assert property (accept_out |-> ##9 pc_load_out == 16'hfffa - {11'h0,
      $past(req_index_in, 10), 1'b0}) else $error("vector");
   AST_LVL: assert property (accept_out |-> ##8 condition_code_reg[5:4] == $past(req_level_in, 9))
      else $error("level");
endmodule
bind ine_core ine_core_chk ine_core_chk_i (.clk_in(clk_in), .srst_in(srst_in),
   .instr_last_in(instr_last_in), .req_valid_in(req_valid_in), .req_level_in(req_level_in),
   .req_index_in(req_index_in), .pc_in(pc_in), .busy_out(busy_out), .accept_out(accept_out),
   .condition_code_reg_out(condition_code_reg_out), .pc_load_out(pc_load_out),
   .pc_load_valid_out(pc_load_valid_out), .mem_addr_out(mem_addr_out),
   .mem_wr_data_out(mem_wr_data_out), .mem_wr_out(mem_wr_out), .sp_out(sp_out));

/* ine_irq_ctrl.sv */
`timescale 1ns/1ps
module ine_irq_ctrl (
   input wire [11:0] pend_in,
   input wire [23:0] lvl_in,
   output logic valid_out,
   output logic [1:0] level_out,
   output logic [3:0] index_out
);
   // Level 3 sources are still shown so the core's refusal gets exercised
   always_comb begin
      valid_out = 1'b0;
      level_out = 2'h3;
      index_out = 4'h0;
      for (int i = 11; i >= 0; i--) begin
         if (pend_in[i] && lvl_in[2*i +: 2] <= level_out) begin
            valid_out = 1'b1;
            level_out = lvl_in[2*i +: 2];
            index_out = 4'(i);
         end
      end
   end
endmodule

/* ine_core_bench.sv */
`timescale 1ns/1ps
`define CMP(a, b) begin checked++; if ((a) !== (b)) begin error_cnt++; \
   $display("unexpected t=%0t got %h exp %h", $time, a, b); end end
module ine_core_bench;
   logic clk_in = 0, srst_in = 1, last = 0, cw = 0, call = 0, ret = 0, return_from_irq_op = 0;
   logic [7:0] cd = 0, rd = 0;
   logic [15:0] pc = 0, old = 0;
   logic [11:0] pend = 0;
   logic [23:0] lvl = 24'hffffff;
   logic [31:0] lf = 32'hdf360fb1;
   logic [7:0] ram [0:1023];
   logic [15:0] exp_q [$];
   int error_cnt = 0, checked = 0;
   wire rv, bz, acc, plv, mw, mr;
   wire [1:0] rl;
   wire [3:0] ri;
   wire [7:0] condition_code_reg, wd;
   wire [15:0] pl, ma, sp;
   ine_irq_ctrl ine_irq_ctrl_i (.pend_in(pend), .lvl_in(lvl), .valid_out(rv), .level_out(rl),
      .index_out(ri));
   ine_core ine_core_i (.clk_in(clk_in), .srst_in(srst_in), .instr_last_in(last),
      .req_valid_in(rv), .req_level_in(rl), .req_index_in(ri), .pc_in(pc), .ccr_wr_data_in(cd),
      .ccr_wr_in(cw), .sp_wr_in(1'b0), .sp_wr_data_in(16'h0), .call_in(call), .ret_in(ret),
      .return_from_irq_op_in(return_from_irq_op), .mem_rd_data_in(rd), .busy_out(bz), .accept_out(acc),
      .condition_code_reg_out(condition_code_reg), .pc_load_out(pl), .pc_load_valid_out(plv),
      .mem_addr_out(ma), .mem_wr_data_out(wd), .mem_wr_out(mw), .mem_rd_out(mr), .sp_out(sp));
   function [31:0] nx(input [31:0] v);
      nx = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   task end_sim;
      if (error_cnt == 0 && checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task step(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask
   task waitidle;
      for (int k = 0; k < 40 && bz !== 1'b0; k++) step(1);
      `CMP(bz, 1'b0)
   endtask
   task req(input [3:0] i, input [1:0] l, input e);
      pend[i] = 1'b1;
      lvl[2*i +: 2] = l;
      step(2);
      `CMP(acc, 1'b0)
      if (e) exp_q.push_back(16'hfffa - {11'h0, i, 1'b0});
      last = 1'b1;
      step(1);
      last = 1'b0;
      `CMP(acc, e)
      waitidle;
   endtask
   task op(input int s);
      {call, ret, return_from_irq_op} = 3'(s);
      step(1);
      {call, ret, return_from_irq_op} = 3'h0;
      waitidle;
      pend = 12'h0;
      lvl = 24'hffffff;
   endtask
   // RAM read is combinational; the core takes read data while its strobe stands
   always @(posedge clk_in) begin
      if (mw) ram[ma[9:0]] <= wd;
   end
   always @* rd = ram[ma[9:0]];
   always @(posedge clk_in) begin
      logic [15:0] e;
      if (plv === 1'b1) begin
         e = exp_q.pop_front();
         `CMP(pl, e)
      end
   end
   initial forever #50 clk_in = ~clk_in;
   initial begin
      #300000;
      error_cnt++;
      end_sim;
   end
   initial begin
      step(6);
      srst_in = 0;
      `CMP(condition_code_reg, 8'h38)
      `CMP(sp, 16'h027f)
      for (int k = 0; k < 4; k++) begin
         lf = nx(lf);
         pc = lf[15:0];
         req(lf[19:16] % 4'd12, 2'h2, 1'b1);
         req(4'h0, 2'h1, 1'b1);
         exp_q.push_back(pc);
         op(1);
         `CMP(condition_code_reg[5:4], 2'h2)
         exp_q.push_back(pc);
         op(1);
         `CMP(condition_code_reg, 8'h38)
         `CMP(sp, 16'h027f)
      end
      req(4'h5, 2'h3, 1'b0);
      op(0);
      cw = 1'b1;
      step(1);
      cw = 1'b0;
      req(4'h1, 2'h1, 1'b0);
      op(0);
      cd = 8'h38;
      cw = 1'b1;
      step(1);
      cw = 1'b0;
      pend[7] = 1'b1;
      lvl[15:14] = 2'h1;
      req(4'h3, 2'h1, 1'b1);
      exp_q.push_back(pc);
      op(1);
      old = pc;
      op(4);
      pc = ~pc;
      exp_q.push_back(old);
      op(2);
      `CMP(sp, 16'h027f)
      step(3);
      `CMP(exp_q.size(), 0)
      end_sim;
   end
endmodule
